/* File: host_model.sv */
// Host register access model driving the serial control port of the flag block
`timescale 1ns/1ps
module host_model
(
    // Clock
    input  wire logic                                   clk,
    // Register port
    output logic                                        reg_rd,
    output logic                                        reg_wr,
    output logic [7:0]                                  reg_addr,
    output sensor_event_flags_pkg::reg_byte_type        reg_wdata,
    input  wire logic [7:0]                             reg_rdata
);
    initial
    begin
        {reg_rd, reg_wr} = 2'b00;
        {reg_addr, reg_wdata} = 16'h0000;
    end

    // One-cycle write strobe; address is scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~v;
    endtask

    // Read data is registered, so it is taken just after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        v = reg_rdata;
    endtask
endmodule // host_model

/* File: range_check.sv */
// Over/under range and level window compare on a 20-bit signed result
`timescale 1ns/1ps
`include "sensor_event_flags_regs.svh"
module range_check
(
    // Result to check
    input  wire sensor_event_flags_pkg::sample_type sample,
    // Window limits, compared against the top eight result bits
    input  wire sensor_event_flags_pkg::reg_byte_type upper,
    input  wire sensor_event_flags_pkg::reg_byte_type lower,
    // Results
    output logic                                     out_of_range,
    output logic                                     outside_window
);
    wire signed [19:0] s_val   = sample;
    wire signed [19:0] s_under = `RESULT_NEG_QUARTER;
    wire signed [7:0]  s_top   = sample[19:12];
    wire signed [7:0]  s_up    = upper;
    wire signed [7:0]  s_lo    = lower;

    assign out_of_range   = (sample == `RESULT_POS_FULL) || (s_val < s_under);
    assign outside_window = (s_top > s_up) || (s_top < s_lo);
endmodule // range_check

/* File: sensor_event_flags_irq.sv */
// Status flags and dual interrupt routing of the optical sensor front end
//
// Summary of operation
// - Almost-full flag sets when FIFO level reaches programmed almost-full level.
// - Almost-full clears on status read, or FIFO data read if option set.
// - Frame-complete flag sets when all enabled slots' results reach the FIFO.
// - Frame-complete clears on status read, or FIFO data read if option set.
// - New-sample flag sets on FIFO push; clears like the other FIFO flags.
// - Ambient overflow flag sets on out-of-range dark result; clears on status read.
// - Overrange equals 0x7FFFF; underrange is below 0xE0000.
// - Exposure overflow flag sets on out-of-range exposure result.
// - Exposure overflow also sets on forward bias; clears on status read.
// - Window flag sets when result is above upper or below lower limit.
// - Dropout flag not set by soft reset; clears on status read or shutdown.
// - Dropout flag drives both interrupt outputs regardless of enables.
`timescale 1ns/1ps
`include "sensor_event_flags_regs.svh"
module sensor_event_flags_irq
#(
    parameter logic [7:0] DEVICE_ID = 8'h5a   // Arbitrary identifier value
)
(
    // Clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   reset_n,
    // Register port from the serial control engine
    input  wire logic                                   reg_rd,
    input  wire logic                                   reg_wr,
    input  wire logic [7:0]                             reg_addr,
    input  wire sensor_event_flags_pkg::reg_byte_type   reg_wdata,
    output logic [7:0]                                  reg_rdata,
    // FIFO side
    input  wire logic                                   fifo_push,
    input  wire logic [8:0]                             fifo_level,
    input  wire logic [7:0]                             fifo_almost_full_level,
    input  wire logic                                   clear_flags_on_fifo_read,
    // Measurement sequencer
    input  wire logic [3:0]                             measurement_slot,
    input  wire logic [`SLOT_COUNT-1:0]                 slot_enable,
    input  wire logic                                   result_valid,
    input  wire sensor_event_flags_pkg::sample_type     dark_result,
    input  wire sensor_event_flags_pkg::sample_type     exposure_result,
    input  wire sensor_event_flags_pkg::sample_type     window_result,
    // Analog status pins, asynchronous
    input  wire logic                                   forward_bias_pin,
    input  wire logic                                   supply_low_pin,
    input  wire logic                                   shutdown_ctl,
    // Health and compliance flags from other status registers
    input  wire logic [7:0]                             health_flags,
    input  wire logic [7:0]                             compliance_flags,
    // Interrupt outputs
    output logic                                        irq_out_a,
    output logic                                        irq_out_b
);
    // ======================================================================
    // Registers
    logic [7:0]                   flags_ff;
    logic [7:0]                   window_source_select_ff;
    logic [7:0]                   window_hysteresis_cfg_ff;
    logic [7:0]                   window1_upper_ff;
    logic [7:0]                   window1_lower_ff;
    logic [7:0]                   window2_upper_ff;
    logic [7:0]                   window2_lower_ff;
    logic [7:0]                   en_a_events_ff;
    logic [7:0]                   en_a_health_ff;
    logic [7:0]                   en_a_compliance_ff;
    logic [7:0]                   en_b_events_ff;
    logic [7:0]                   en_b_health_ff;
    logic [7:0]                   en_b_compliance_ff;
    logic [`SLOT_COUNT-1:0]       slots_done_ff;
    logic [1:0]                   fbias_sync_ff;
    logic [1:0]                   supply_sync_ff;
    logic [1:0]                   shutdown_ctl_sync_ff;
    logic                         shutdown_ctl_prev_ff;
    logic [7:0]                   reg_rdata_ff;
    logic                         irq_a_ff;
    logic                         irq_b_ff;

    // ======================================================================
    // Range checks
    logic dark_oor;
    logic exp_oor;
    logic win1_out;
    logic win2_out;
    logic unused_dark_win;
    logic unused_exp_win;
    logic unused_w1_oor;
    logic unused_w2_oor;

    range_check u_dark
    (
        .sample         (dark_result),
        .upper          (8'h00),
        .lower          (8'h00),
        .out_of_range   (dark_oor),
        .outside_window (unused_dark_win)
    );
    range_check u_exp
    (
        .sample         (exposure_result),
        .upper          (8'h00),
        .lower          (8'h00),
        .out_of_range   (exp_oor),
        .outside_window (unused_exp_win)
    );
    range_check u_win1
    (
        .sample         (window_result),
        .upper          (window1_upper_ff),
        .lower          (window1_lower_ff),
        .out_of_range   (unused_w1_oor),
        .outside_window (win1_out)
    );
    range_check u_win2
    (
        .sample         (window_result),
        .upper          (window2_upper_ff),
        .lower          (window2_lower_ff),
        .out_of_range   (unused_w2_oor),
        .outside_window (win2_out)
    );

    // ======================================================================
    // Decode
    wire status_rd    = reg_rd && (reg_addr == `OFS_EVENT_FLAGS_PRIMARY);
    wire fifo_rd      = reg_rd && (reg_addr == `OFS_FIFO_DATA);
    wire fifo_rd_clr  = fifo_rd && clear_flags_on_fifo_read;
    wire slot_ok      = measurement_slot < 4'(`SLOT_COUNT);
    wire [`SLOT_COUNT-1:0] slot_hot = slot_ok ?
                                      (`SLOT_COUNT'(1) << measurement_slot) : '0;
    wire [`SLOT_COUNT-1:0] nxt_slots_done = slots_done_ff | (result_valid ? slot_hot : '0);
    // frame ends once every enabled slot has produced a result
    wire frame_done   = result_valid && (slot_enable != '0)
                        && ((nxt_slots_done & slot_enable) == slot_enable);
    wire win1_sel     = measurement_slot == window_source_select_ff[3:0];
    wire win2_sel     = measurement_slot == window_source_select_ff[7:4];
    wire shutdown_ctl_rise    = shutdown_ctl_sync_ff[1] && !shutdown_ctl_prev_ff;

    // Set terms per flag
    wire [7:0] set_vec;
    assign set_vec[`BIT_ALMOST_FULL]    = fifo_level >= {1'b0, fifo_almost_full_level};
    assign set_vec[`BIT_FRAME_COMPLETE] = frame_done;
    assign set_vec[`BIT_NEW_SAMPLE]     = fifo_push;
    assign set_vec[`BIT_AMBIENT_OVF]    = result_valid && dark_oor;
    assign set_vec[`BIT_EXPOSURE_OVF]   = (result_valid && exp_oor) || fbias_sync_ff[1];
    // window events on the selected slot
    assign set_vec[`BIT_WINDOW2]        = result_valid && win2_sel && win2_out;
    assign set_vec[`BIT_WINDOW1]        = result_valid && win1_sel && win1_out;
    // only the supply monitor sets dropout, never a soft reset
    assign set_vec[`BIT_SUPPLY_DROPOUT] = supply_sync_ff[1];

    // Clear terms
    wire [7:0] fifo_clr_mask = (8'h01 << `BIT_ALMOST_FULL) | (8'h01 << `BIT_FRAME_COMPLETE)
                               | (8'h01 << `BIT_NEW_SAMPLE);
    // a status read clears only what it returned
    // FIFO read clears FIFO flags when enabled
    // frame flag cleared the same way
    wire [7:0] clr_vec = (status_rd ? flags_ff : 8'h00)
                         | (fifo_rd_clr ? fifo_clr_mask : 8'h00)
                         | (shutdown_ctl_rise ? 8'h01 << `BIT_SUPPLY_DROPOUT : 8'h00);
    // Set wins over clear so no event is lost
    wire [7:0] nxt_flags = (flags_ff & ~clr_vec) | set_vec;

    wire hit_a = |(nxt_flags & en_a_events_ff) | |(health_flags & en_a_health_ff)
                 | |(compliance_flags & en_a_compliance_ff);
    wire hit_b = |(nxt_flags & en_b_events_ff) | |(health_flags & en_b_health_ff)
                 | |(compliance_flags & en_b_compliance_ff);
    wire nxt_irq_a = hit_a || nxt_flags[`BIT_SUPPLY_DROPOUT];
    wire nxt_irq_b = hit_b || nxt_flags[`BIT_SUPPLY_DROPOUT];

    logic [7:0] nxt_rdata;
    always_comb
    begin
        unique case (reg_addr)
            `OFS_EVENT_FLAGS_PRIMARY:     nxt_rdata = flags_ff;
            `OFS_WINDOW_SOURCE_SELECT:    nxt_rdata = window_source_select_ff;
            `OFS_WINDOW_HYSTERESIS_CFG:   nxt_rdata = window_hysteresis_cfg_ff;
            `OFS_WINDOW1_UPPER_LIMIT:     nxt_rdata = window1_upper_ff;
            `OFS_WINDOW1_LOWER_LIMIT:     nxt_rdata = window1_lower_ff;
            `OFS_WINDOW2_UPPER_LIMIT:     nxt_rdata = window2_upper_ff;
            `OFS_WINDOW2_LOWER_LIMIT:     nxt_rdata = window2_lower_ff;
            `OFS_IRQ_A_ENABLE_EVENTS:     nxt_rdata = en_a_events_ff;
            `OFS_IRQ_A_ENABLE_HEALTH:     nxt_rdata = en_a_health_ff;
            `OFS_IRQ_A_ENABLE_COMPLIANCE: nxt_rdata = en_a_compliance_ff;
            `OFS_IRQ_B_ENABLE_EVENTS:     nxt_rdata = en_b_events_ff;
            `OFS_IRQ_B_ENABLE_HEALTH:     nxt_rdata = en_b_health_ff;
            `OFS_IRQ_B_ENABLE_COMPLIANCE: nxt_rdata = en_b_compliance_ff;
            `OFS_DEVICE_IDENTIFIER:       nxt_rdata = DEVICE_ID;
            default:                      nxt_rdata = 8'h00;
        endcase
    end

    // ======================================================================
    // Synchronisers and flags
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            fbias_sync_ff  <= 2'h0;
            supply_sync_ff <= 2'h0;
            shutdown_ctl_sync_ff   <= 2'h0;
            shutdown_ctl_prev_ff   <= 1'b0;
            flags_ff       <= `RST_EVENT_FLAGS;
            slots_done_ff  <= '0;
            reg_rdata_ff   <= 8'h00;
            // Dropout is set out of reset and cannot be masked
            irq_a_ff       <= 1'b1;
            irq_b_ff       <= 1'b1;
        end
        else
        begin
            fbias_sync_ff  <= {fbias_sync_ff[0], forward_bias_pin};
            supply_sync_ff <= {supply_sync_ff[0], supply_low_pin};
            shutdown_ctl_sync_ff   <= {shutdown_ctl_sync_ff[0], shutdown_ctl};
            shutdown_ctl_prev_ff   <= shutdown_ctl_sync_ff[1];
            flags_ff       <= nxt_flags;
            slots_done_ff  <= frame_done ? '0 : nxt_slots_done;
            reg_rdata_ff   <= reg_rd ? nxt_rdata : reg_rdata_ff;
            irq_a_ff       <= nxt_irq_a;
            irq_b_ff       <= nxt_irq_b;
        end
    end

    // ======================================================================
    // Writable configuration
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            window_source_select_ff  <= `RST_ZERO;
            window_hysteresis_cfg_ff <= `RST_ZERO;
            window1_upper_ff         <= `RST_ZERO;
            window1_lower_ff         <= `RST_ZERO;
            window2_upper_ff         <= `RST_ZERO;
            window2_lower_ff         <= `RST_ZERO;
            en_a_events_ff           <= `RST_ZERO;
            en_a_health_ff           <= `RST_ZERO;
            en_a_compliance_ff       <= `RST_ZERO;
            en_b_events_ff           <= `RST_ZERO;
            en_b_health_ff           <= `RST_ZERO;
            en_b_compliance_ff       <= `RST_ZERO;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `OFS_WINDOW_SOURCE_SELECT:    window_source_select_ff  <= reg_wdata;
                `OFS_WINDOW_HYSTERESIS_CFG:   window_hysteresis_cfg_ff <= reg_wdata;
                `OFS_WINDOW1_UPPER_LIMIT:     window1_upper_ff         <= reg_wdata;
                `OFS_WINDOW1_LOWER_LIMIT:     window1_lower_ff         <= reg_wdata;
                `OFS_WINDOW2_UPPER_LIMIT:     window2_upper_ff         <= reg_wdata;
                `OFS_WINDOW2_LOWER_LIMIT:     window2_lower_ff         <= reg_wdata;
                `OFS_IRQ_A_ENABLE_EVENTS:     en_a_events_ff           <= reg_wdata;
                `OFS_IRQ_A_ENABLE_HEALTH:     en_a_health_ff           <= reg_wdata;
                `OFS_IRQ_A_ENABLE_COMPLIANCE: en_a_compliance_ff       <= reg_wdata;
                `OFS_IRQ_B_ENABLE_EVENTS:     en_b_events_ff           <= reg_wdata;
                `OFS_IRQ_B_ENABLE_HEALTH:     en_b_health_ff           <= reg_wdata;
                `OFS_IRQ_B_ENABLE_COMPLIANCE: en_b_compliance_ff       <= reg_wdata;
                default:                      ;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign irq_out_a = irq_a_ff;
    assign irq_out_b = irq_b_ff;

    // ======================================================================
    // Checks
    chk_afull_set: assert property (@(posedge clk) disable iff (!reset_n)
        (fifo_level >= {1'b0, fifo_almost_full_level}) |=> flags_ff[`BIT_ALMOST_FULL])
        else $error("almost-full flag not set at level");
    chk_fifo_rd_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (fifo_rd_clr && !set_vec[`BIT_ALMOST_FULL]) |=> !flags_ff[`BIT_ALMOST_FULL])
        else $error("almost-full not cleared by fifo read");
    chk_frame_set: assert property (@(posedge clk) disable iff (!reset_n)
        frame_done |=> flags_ff[`BIT_FRAME_COMPLETE])
        else $error("frame flag missing");
    chk_frame_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (status_rd && !frame_done) |=> !flags_ff[`BIT_FRAME_COMPLETE])
        else $error("frame flag not cleared by status read");
    chk_new_sample: assert property (@(posedge clk) disable iff (!reset_n)
        fifo_push |=> flags_ff[`BIT_NEW_SAMPLE])
        else $error("new sample flag missing");
    chk_ambient_ovf: assert property (@(posedge clk) disable iff (!reset_n)
        (result_valid && dark_result == `RESULT_POS_FULL) |=> flags_ff[`BIT_AMBIENT_OVF])
        else $error("ambient overflow missed");
    chk_exposure_ovf: assert property (@(posedge clk) disable iff (!reset_n)
        (result_valid && exp_oor) |=> flags_ff[`BIT_EXPOSURE_OVF])
        else $error("exposure overflow missed");
    chk_dropout_nmi: assert property (@(posedge clk) disable iff (!reset_n)
        flags_ff[`BIT_SUPPLY_DROPOUT] |-> (irq_out_a && irq_out_b))
        else $error("dropout not on both interrupts");
    chk_read_keeps_new: assert property (@(posedge clk) disable iff (!reset_n)
        (status_rd && !flags_ff[`BIT_NEW_SAMPLE] && fifo_push) |=> flags_ff[`BIT_NEW_SAMPLE])
        else $error("event lost during status read");
    chk_irq_a_follow: assert property (@(posedge clk) disable iff (!reset_n)
        (|(flags_ff & en_a_events_ff) && $stable(en_a_events_ff)) |-> irq_out_a)
        else $error("interrupt a not asserted");
endmodule // sensor_event_flags_irq

/* File: sensor_event_flags_pkg.sv */
// Types shared by the event flag block
package sensor_event_flags_pkg;
    typedef logic [7:0]  reg_byte_type;
    typedef logic [19:0] sample_type;
endpackage

/* File: sensor_event_flags_regs.svh */
// Register offsets, field positions, reset values and limits of the event flag block
`ifndef SENSOR_EVENT_FLAGS_REGS_SVH
`define SENSOR_EVENT_FLAGS_REGS_SVH

// ==========================================================================
// Register offsets
`define OFS_EVENT_FLAGS_PRIMARY    8'h00
`define OFS_FIFO_DATA              8'h08
`define OFS_WINDOW_SOURCE_SELECT   8'h68
`define OFS_WINDOW_HYSTERESIS_CFG  8'h69
`define OFS_WINDOW1_UPPER_LIMIT    8'h6a
`define OFS_WINDOW1_LOWER_LIMIT    8'h6b
`define OFS_WINDOW2_UPPER_LIMIT    8'h6c
`define OFS_WINDOW2_LOWER_LIMIT    8'h6d
`define OFS_IRQ_A_ENABLE_EVENTS    8'h78
`define OFS_IRQ_A_ENABLE_HEALTH    8'h79
`define OFS_IRQ_A_ENABLE_COMPLIANCE 8'h7a
`define OFS_IRQ_B_ENABLE_EVENTS    8'h7c
`define OFS_IRQ_B_ENABLE_HEALTH    8'h7d
`define OFS_IRQ_B_ENABLE_COMPLIANCE 8'h7e
`define OFS_DEVICE_IDENTIFIER      8'hff

// ==========================================================================
// Field positions in the primary flag register
`define BIT_ALMOST_FULL     7
`define BIT_FRAME_COMPLETE  6
`define BIT_NEW_SAMPLE      5
`define BIT_AMBIENT_OVF     4
`define BIT_EXPOSURE_OVF    3
`define BIT_WINDOW2         2
`define BIT_WINDOW1         1
`define BIT_SUPPLY_DROPOUT  0

// ==========================================================================
// Reset values and range limits
`define RST_EVENT_FLAGS     8'h01
`define RST_ZERO            8'h00
`define RESULT_POS_FULL     20'h7_ffff
`define RESULT_NEG_QUARTER  20'he_0000
`define SLOT_COUNT          9

`endif

/* File: tb_top.sv */
// Self-checking testbench for the event flag and interrupt block
`timescale 1ns/1ps
module tb_top;
    // ==========================================================
    // Signals
    logic clk, reset_n, reg_rd, reg_wr, fifo_push, result_valid, irq_out_a, irq_out_b;
    logic forward_bias_pin, supply_low_pin, shutdown_ctl, clear_flags_on_fifo_read;
    logic [7:0] reg_addr, reg_rdata, fifo_almost_full_level, health_flags, compliance_flags;
    logic [8:0] fifo_level, slot_enable;
    logic [3:0] measurement_slot;
    sensor_event_flags_pkg::reg_byte_type reg_wdata;
    sensor_event_flags_pkg::sample_type   dark_result, exposure_result, window_result;
    int         n_fail;
    int         check_count;
    logic [7:0] d;

    sensor_event_flags_irq #(.DEVICE_ID(8'h3c)) dut  // Identifier value is arbitrary
    (
        .clk, .reset_n, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .fifo_push, .fifo_level, .fifo_almost_full_level, .clear_flags_on_fifo_read,
        .measurement_slot, .slot_enable, .result_valid, .dark_result, .exposure_result,
        .window_result, .forward_bias_pin, .supply_low_pin, .shutdown_ctl,
        .health_flags, .compliance_flags, .irq_out_a, .irq_out_b
    );
    host_model host (.clk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);

    // ==========================================================
    // Helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic st(input logic [7:0] exp);
        host.rd(8'h00, d);
        check(d, exp);
    endtask
    task automatic irqs(input logic [1:0] e);
        #1;
        check({6'h00, irq_out_a, irq_out_b}, {6'h00, e});
    endtask
    task automatic push;
        @(posedge clk);
        fifo_push <= 1'b1;
        @(posedge clk);
        fifo_push <= 1'b0;
    endtask
    task automatic res(input logic [3:0] s, input logic [19:0] dk, ex, w);
        @(posedge clk);
        {measurement_slot, dark_result, exposure_result, window_result} <= {s, dk, ex, w};
        result_valid <= 1'b1;
        @(posedge clk);
        result_valid <= 1'b0;
    endtask
    // Async pins go through a two-stage synchroniser, hence the long holds
    task automatic pin(input int k);
        @(posedge clk);
        {forward_bias_pin, supply_low_pin, shutdown_ctl} <= 3'b100 >> k;
        tick(4);
        {forward_bias_pin, supply_low_pin, shutdown_ctl} <= 3'b000;
        tick(4);
    endtask
    task automatic levels(input logic [7:0] h, input logic [7:0] c);
        @(posedge clk);
        {health_flags, compliance_flags} <= {h, c};
        tick(2);
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_regs;
        logic [7:0] a [12];
        a = '{8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h78, 8'h79, 8'h7a, 8'h7c, 8'h7d, 8'h7e};
        foreach (a[i])
        begin
            host.rd(a[i], d);
            check(d, 8'h00);
            host.wr(a[i], 8'ha5 ^ a[i]);
            host.rd(a[i], d);
            check(d, 8'ha5 ^ a[i]);
            host.wr(a[i], 8'h00);
        end
        host.wr(8'hff, 8'h00);
        host.rd(8'hff, d);
        check(d, 8'h3c);
        host.rd(8'h20, d);
        check(d, 8'h00);
        host.wr(8'h00, 8'hff);
        st(8'h00);
    endtask

    task automatic test_fifo;
        @(posedge clk);
        {fifo_almost_full_level, fifo_level} <= {8'h07, 9'h006};
        tick(2);
        st(8'h00);
        fifo_level <= 9'h007;
        tick(2);
        fifo_level <= 9'h000;
        st(8'h80);
        st(8'h00);
        clear_flags_on_fifo_read <= 1'b1;
        push();
        host.rd(8'h08, d);
        st(8'h00);
        clear_flags_on_fifo_read <= 1'b0;
        push();
        host.rd(8'h08, d);
        st(8'h20);
        fork
            host.rd(8'h00, d);
            push();
        join
        check(d, 8'h00);
        st(8'h20);
    endtask

    task automatic test_frame;
        slot_enable <= 9'h005;
        res(4'h0, 20'h0_0000, 20'h0_0000, 20'h0_0000);
        st(8'h00);
        res(4'h2, 20'h0_0000, 20'h0_0000, 20'h0_0000);
        st(8'h40);
        st(8'h00);
        clear_flags_on_fifo_read <= 1'b1;
        res(4'h0, 20'h0_0000, 20'h0_0000, 20'h0_0000);
        res(4'h2, 20'h0_0000, 20'h0_0000, 20'h0_0000);
        host.rd(8'h08, d);
        st(8'h00);
        slot_enable <= 9'h100;
    endtask

    task automatic test_range;
        logic [19:0] v [5];
        logic [7:0]  b [4];
        logic        hit [5];
        v = '{20'h7_ffff, 20'h7_fffe, 20'he_0000, 20'hd_ffff, 20'h0_0000};
        hit = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        foreach (v[i])
        begin
            res(4'h0, v[i], 20'h0_0000, 20'h0_0000);
            st(hit[i] ? 8'h10 : 8'h00);
            res(4'h0, 20'h0_0000, v[i], 20'h0_0000);
            st(hit[i] ? 8'h08 : 8'h00);
        end
        pin(0);
        st(8'h08);
        st(8'h00);
        host.wr(8'h68, 8'h21);
        host.wr(8'h6a, 8'h10);
        host.wr(8'h6b, 8'hf0);
        host.wr(8'h6c, 8'h10);
        host.wr(8'h6d, 8'hf0);
        b = '{8'h11, 8'h10, 8'hf0, 8'hef};
        foreach (b[i])
        begin
            res(4'h1, 20'h0_0000, 20'h0_0000, {b[i], 12'h000});
            st(hit[i] ? 8'h02 : 8'h00);
            res(4'h2, 20'h0_0000, 20'h0_0000, {b[i], 12'h000});
            st(hit[i] ? 8'h04 : 8'h00);
        end
    endtask

    task automatic test_irq;
        host.wr(8'h78, 8'h20);
        host.wr(8'h7a, 8'h01);
        host.wr(8'h7d, 8'h40);
        push();
        irqs(2'b10);
        st(8'h20);
        irqs(2'b00);
        levels(8'h40, 8'h00);
        irqs(2'b01);
        levels(8'h00, 8'h01);
        irqs(2'b10);
        levels(8'h00, 8'h00);
        irqs(2'b00);
        pin(1);
        irqs(2'b11);
        st(8'h01);
        pin(1);
        pin(2);
        irqs(2'b00);
        st(8'h00);
    endtask

    // ==========================================================
    // Verdict, clock, watchdog and main sequence
    task automatic stop_test;
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    initial
    begin
        {n_fail, check_count} = '0;
        reset_n = 1'b0;
        {fifo_push, result_valid, forward_bias_pin, supply_low_pin, shutdown_ctl} = '0;
        {clear_flags_on_fifo_read, fifo_level} = '0;
        // High threshold so almost-full stays quiet until its own scenario
        fifo_almost_full_level = 8'hff;
        {measurement_slot, slot_enable, health_flags, compliance_flags} = '0;
        {dark_result, exposure_result, window_result} = '0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        irqs(2'b11);
        st(8'h01);
        st(8'h00);
        irqs(2'b00);
        test_regs();
        test_fifo();
        test_frame();
        test_range();
        test_irq();
        stop_test();
    end
endmodule // tb_top
